// ==== tb/frt_pins_model.sv ====
// Model of the capture and external clock pins.
// Assumes the bench calls pulse from its main thread.
`timescale 1ns/1ps
module frt_pins_model (
	input	wire logic	clk_i,	// Bench clock
	output	logic		cap1_o,	// Capture pin one
	output	logic		cap2_o,	// Capture pin two
	output	logic		ext_o	// External clock pin
);
	// ****************
	// Pin pulses
	// ****************
	logic [2:0]	pin_q;
	assign {ext_o, cap2_o, cap1_o} = pin_q;
	// Pins idle high, the level the synchronisers leave reset with
	initial pin_q = 3'h7;
	// Each level held eight cycles, then time to settle
	task automatic pulse(input int sel);
		repeat (2) begin
			repeat (8) @(posedge clk_i);
			pin_q[sel] <= !pin_q[sel];
		end
		repeat (6) @(posedge clk_i);
	endtask
endmodule

// ==== tb/frt_timer_props.sv ====
// Checker on the timer's top ports.
// Assumes frt_pkg is compiled first; bound onto frt_timer below.
`timescale 1ns/1ps
module frt_timer_props (
	input	wire logic			CLK_I,
	input	wire logic			RESET_I,
	input	wire logic			CE_I,
	input	wire frt_pkg::frt_avs_req_t	AVS_REQ_I,
	input	wire logic [31:0]		AVS_READDATA_O,
	input	wire logic			AVS_WAITREQUEST_O,
	input	wire logic			HALT_I,
	input	wire logic			IMASK_I,
	input	wire logic			IRQ_O,
	input	wire logic [15:0]		COUNT_O
);
	import frt_pkg::*;
	logic	tk;
	logic	rtk;
	logic	ld;
	assign tk = (AVS_REQ_I.read | AVS_REQ_I.write) & AVS_WAITREQUEST_O & CE_I;
	assign rtk = tk & AVS_REQ_I.read;
	assign ld = tk & AVS_REQ_I.write & AVS_REQ_I.byteenable[0]
		& (AVS_REQ_I.address[5:2] == REG_CNT_LO | AVS_REQ_I.address[5:2] == REG_ALT_LO);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// ****************
	// Properties
	// ****************
	ack_one_cycle_a: assert property (tk |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
		else $error("acknowledge not one cycle");
	idle_no_ack_a: assert property (!AVS_REQ_I.read && !AVS_REQ_I.write |=> AVS_WAITREQUEST_O)
		else $error("acknowledge without request");
	rdata_upper_a: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	rdata_hold_a: assert property (!rtk |=> $stable(AVS_READDATA_O))
		else $error("read data moved without read");
	count_step_a: assert property (!$stable(COUNT_O) |->
		COUNT_O == $past(COUNT_O) + 16'h0001 || COUNT_O == CNT_RELOAD)
		else $error("counter jumped");
	count_reload_a: assert property (ld |=> COUNT_O == CNT_RELOAD)
		else $error("no reload after low write");
	halt_hold_a: assert property (HALT_I && !ld |=> $stable(COUNT_O))
		else $error("counter moved in halt");
	mask_irq_a: assert property (IMASK_I && CE_I |=> !IRQ_O)
		else $error("interrupt while masked");
	cover property (rtk);
	cover property (COUNT_O == 16'h0000 && $past(COUNT_O) == CNT_MAX);
	cover property ($rose(IRQ_O));
endmodule
bind frt_timer frt_timer_props props_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I),
	.AVS_REQ_I(AVS_REQ_I), .AVS_READDATA_O(AVS_READDATA_O), .HALT_I(HALT_I),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IMASK_I(IMASK_I), .IRQ_O(IRQ_O),
	.COUNT_O(COUNT_O));

// ==== tb/frt_timer_test.sv ====
// Bench for the free-running timer with capture.
// Assumes frt_pkg, frt_timer, its checker and the pin model.
`timescale 1ns/1ps
module frt_timer_test;
	import frt_pkg::*;
	// ****************
	// Signals and blocks
	// ****************
	logic		clk = 1'b0;
	logic		rst = 1'b1;
	logic		ce = 1'b1;
	logic		irq2;
	logic [15:0]	count2;
	frt_avs_req_t	req = '{6'h00, 1'b0, 1'b0, 32'h0000_0000, 4'hF};
	logic [31:0]	rdata;
	logic		wreq;
	logic		halt = 1'b0;
	logic		imask = 1'b1;
	logic		cap1;
	logic		cap2;
	logic		ext;
	logic		irq;
	logic [15:0]	count;
	logic [7:0]	rd;
	int		n_fail = 0;
	int		checks = 0;
	always #2 clk = !clk;
	frt_timer dut_u (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .AVS_REQ_I(req),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .HALT_I(halt), .IMASK_I(imask),
		.CAP1_I(cap1), .CAP2_I(cap2), .EXTERNAL_CLOCK_PIN_I(ext), .IRQ_O(irq), .COUNT_O(count));
	// Second copy with every timer pin absent
	frt_timer #(.PIN_PRESENT(3'h0)) dut_nopin_u (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
		.AVS_REQ_I(req), .AVS_READDATA_O(), .AVS_WAITREQUEST_O(), .HALT_I(halt),
		.IMASK_I(imask), .CAP1_I(cap1), .CAP2_I(cap2), .EXTERNAL_CLOCK_PIN_I(ext), .IRQ_O(irq2),
		.COUNT_O(count2));
	frt_pins_model pins_u (.clk_i(clk), .cap1_o(cap1), .cap2_o(cap2), .ext_o(ext));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
		@(posedge clk);
		req.address <= {idx, 2'b00};
		req.read <= !wr;
		req.write <= wr;
		req.writedata <= {24'h5A_5A5A, wd};
		do @(posedge clk); while (wreq !== 1'b0);
		rd = rdata[7:0];
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk({8'h00, rd}, {8'h00, exp});
	endtask
	task automatic t_divide();
		logic [1:0]	code [3] = '{CSEL_DIV2, CSEL_DIV4, CSEL_DIV8};
		logic [15:0]	exp;
		for (int d = 0; d < 3; d++) begin
			halt <= 1'b0;
			xfer(1'b1, REG_CTRL2, {4'h0, code[d], 2'b00});
			xfer(1'b1, REG_CNT_LO, 8'h00);
			repeat (17) @(posedge clk);
			halt <= 1'b1;
			exp = CNT_RELOAD + 16'(18 >> (d + 1));
			rdc(REG_CNT_HI, exp[15:8]);
			rdc(REG_CNT_LO, exp[7:0]);
		end
		$display("divide test done");
	endtask
	task automatic t_ce();
		halt <= 1'b0;
		xfer(1'b1, REG_CTRL2, {4'h0, CSEL_DIV2, 2'b00});
		xfer(1'b1, REG_CNT_LO, 8'h00);
		ce <= 1'b0;
		repeat (16) @(posedge clk);
		chk(count, CNT_RELOAD);
		ce <= 1'b1;
		halt <= 1'b1;
		rdc(REG_CNT_HI, CNT_RELOAD[15:8]);
		rdc(REG_CNT_LO, CNT_RELOAD[7:0]);
		$display("clock enable test done");
	endtask
	task automatic t_ext();
		halt <= 1'b0;
		xfer(1'b1, REG_CTRL2, 8'h0D);
		xfer(1'b1, REG_ALT_LO, 8'h00);
		rdc(REG_ALT_HI, 8'hFF);
		pins_u.pulse(2);
		pins_u.pulse(2);
		rdc(REG_ALT_HI, 8'hFF);
		rdc(REG_ALT_LO, 8'hFC);
		pins_u.pulse(2);
		rdc(REG_STATUS, 8'h20);
		rdc(REG_CNT_LO, 8'hFF);
		rdc(REG_STATUS, 8'h00);
		pins_u.pulse(2);
		rdc(REG_STATUS, 8'h20);
		rdc(REG_ALT_LO, 8'h00);
		rdc(REG_STATUS, 8'h20);
		xfer(1'b1, REG_CTRL1, 8'h20);
		repeat (3) @(posedge clk);
		chk({15'h0000, irq}, 16'h0000);
		imask <= 1'b0;
		repeat (3) @(posedge clk);
		chk({15'h0000, irq}, 16'h0001);
		rdc(REG_CNT_LO, 8'h00);
		rdc(REG_STATUS, 8'h00);
		chk({15'h0000, irq}, 16'h0000);
		chk(count, 16'h0000);
		chk(count2, CNT_RELOAD);
		$display("external clock test done");
	endtask
	task automatic t_cap();
		xfer(1'b1, REG_CTRL1, 8'h82);
		pins_u.pulse(0);
		rdc(REG_STATUS, 8'h80);
		chk({15'h0000, irq}, 16'h0001);
		rdc(REG_CAP1_HI, 8'h00);
		pins_u.pulse(2);
		pins_u.pulse(0);
		rdc(REG_CAP1_LO, 8'h00);
		pins_u.pulse(0);
		rdc(REG_CAP1_HI, 8'h00);
		rdc(REG_CAP1_LO, 8'h01);
		rdc(REG_STATUS, 8'h80);
		rdc(REG_CAP1_LO, 8'h01);
		rdc(REG_STATUS, 8'h00);
		xfer(1'b1, REG_CTRL2, 8'h2D);
		pins_u.pulse(1);
		pins_u.pulse(2);
		pins_u.pulse(0);
		rdc(REG_CAP1_HI, 8'h00);
		rdc(REG_CAP1_LO, 8'h01);
		rdc(REG_CAP2_HI, 8'h00);
		rdc(REG_CAP2_LO, 8'h01);
		chk({15'h0000, irq}, 16'h0001);
		chk({15'h0000, irq2}, 16'h0000);
		req.byteenable <= 4'hE;
		xfer(1'b1, REG_CTRL1, 8'h00);
		req.byteenable <= 4'hF;
		rdc(REG_CTRL1, 8'h82);
		chk({15'h0000, irq}, 16'h0001);
		$display("capture test done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************
	// Sequence and watchdog
	// ****************
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_divide();
		t_ce();
		t_ext();
		t_cap();
		end_of_test();
	end
	initial begin
		#40000;
		n_fail++;
		end_of_test();
	end
endmodule

// ==== verilog/frt_pkg.sv ====
// Package for the free-running timer with two capture channels.
// Assumes a byte-wide register set mapped one register per 32-bit word.
package frt_pkg;

	// ****************************************
	// Register word indexes, byte address is index times four
	// ****************************************
	localparam logic [3:0] REG_CNT_HI  = 4'h0;
	localparam logic [3:0] REG_CNT_LO  = 4'h1;
	localparam logic [3:0] REG_ALT_HI  = 4'h2;
	localparam logic [3:0] REG_ALT_LO  = 4'h3;
	localparam logic [3:0] REG_CAP1_HI = 4'h4;
	localparam logic [3:0] REG_CAP1_LO = 4'h5;
	localparam logic [3:0] REG_CAP2_HI = 4'h6;
	localparam logic [3:0] REG_CAP2_LO = 4'h7;
	localparam logic [3:0] REG_CTRL1   = 4'h8;
	localparam logic [3:0] REG_CTRL2   = 4'h9;
	localparam logic [3:0] REG_STATUS  = 4'hA;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL1_CAP_IE   = 7;
	localparam int CTRL1_OVF_IE   = 5;
	localparam int CTRL1_CAP1_EDG = 1;
	localparam int CTRL2_OPM      = 5;
	localparam int CTRL2_PWM      = 4;
	localparam int CTRL2_CSEL_HI  = 3;
	localparam int CTRL2_CSEL_LO  = 2;
	localparam int CTRL2_CAP2_EDG = 1;
	localparam int CTRL2_EXT_EDG  = 0;
	localparam int STAT_CAP1_FLAG = 7;
	localparam int STAT_OVF_FLAG  = 5;
	localparam int STAT_CAP2_FLAG = 4;

	// ****************************************
	// Values after reset and encodings
	// ****************************************
	localparam logic [15:0] CNT_RELOAD  = 16'hFFFC;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [15:0] CAP_RESET   = 16'h0000;
	localparam logic [1:0]  CSEL_EXT    = 2'h3;
	localparam logic [1:0]  CSEL_DIV2   = 2'h0;
	localparam logic [1:0]  CSEL_DIV4   = 2'h1;
	localparam logic [1:0]  CSEL_DIV8   = 2'h2;
	localparam logic [2:0]  PRESC_RESET = 3'h0;
	localparam int          NUM_CAP     = 2;

	// ****************************************
	// Bus request carrier
	// ****************************************
	typedef struct packed {
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} frt_avs_req_t;

	typedef enum logic [0:0] {
		BUS_WAIT = 1'b0,
		BUS_DONE = 1'b1
	} frt_bus_state_t;

endpackage

// ==== verilog/frt_timer.sv ====
// Free-running 16-bit timer with prescaler, external clock and two input captures.
// Assumes an Avalon-MM master on CLK_I and asynchronous pins for capture and clock.
`timescale 1ns/1ps

module frt_timer #(
	parameter logic [1:0] DIV2_CODE   = frt_pkg::CSEL_DIV2, // Select code, divide by two
	parameter logic [1:0] DIV4_CODE   = frt_pkg::CSEL_DIV4, // Select code, divide by four
	parameter logic [1:0] DIV8_CODE   = frt_pkg::CSEL_DIV8, // Select code, divide by eight
	parameter logic [2:0] PIN_PRESENT = 3'h7                // Bit0 cap1, bit1 cap2, bit2 ext
) (
	input  wire logic                 CLK_I,             // Clock, 250 MHz
	input  wire logic                 RESET_I,           // Async reset, active high
	input  wire logic                 CE_I,              // Clock enable
	input  wire frt_pkg::frt_avs_req_t AVS_REQ_I,        // Avalon request
	output logic [31:0]               AVS_READDATA_O,    // Avalon read data
	output logic                      AVS_WAITREQUEST_O, // Avalon waitrequest
	input  wire logic                 HALT_I,            // CPU in halt
	input  wire logic                 IMASK_I,           // Global interrupt mask
	input  wire logic                 CAP1_I,            // Capture pin one
	input  wire logic                 CAP2_I,            // Capture pin two
	input  wire logic                 EXTERNAL_CLOCK_PIN_I,          // External clock pin
	output logic                      IRQ_O,             // Timer interrupt request
	output logic [15:0]               COUNT_O            // Counter value
);
	import frt_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0]    cnt_q;
	logic [2:0]     presc_q;
	logic [7:0]     ctrl1_q;
	logic [7:0]     ctrl2_q;
	logic [7:0]     lo_buf_q;
	logic           seq_q;
	logic           ovf_q;
	logic           ovf_arm_q;
	logic           irq_q;
	frt_bus_state_t bus_q;
	logic [31:0]    rdata_q;
	logic           waitreq_q;
	logic [2:0]     pin_raw;
	logic [2:0]     sync1_q;
	logic [2:0]     sync2_q;
	logic [2:0]     prev_q;
	logic           take;
	logic           rd_take;
	logic           wr_take;
	logic [3:0]     sel;
	logic           run;
	logic           tick;
	logic           ext_edge;
	logic           reload;
	logic           ovf_evt;
	logic           cnt_lo_acc;
	logic [1:0]     csel;
	logic [7:0]     rd_mux;
	logic [7:0]     status;
	logic [15:0]    cap_q     [NUM_CAP];
	logic           cap_flag_q[NUM_CAP];
	logic           cap_arm_q [NUM_CAP];
	logic           cap_blk_q [NUM_CAP];
	logic           cap_evt   [NUM_CAP];

	function automatic logic hit(input logic [3:0] s, input logic [3:0] r);
		hit = (s == r);
	endfunction

	// ****************************************
	// Avalon slave, one wait cycle per access
	// ****************************************
	assign sel     = AVS_REQ_I.address[5:2];
	assign take    = (bus_q == BUS_WAIT) && (AVS_REQ_I.read || AVS_REQ_I.write);
	assign rd_take = take && AVS_REQ_I.read;
	assign wr_take = take && AVS_REQ_I.write && AVS_REQ_I.byteenable[0];

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			bus_q <= BUS_WAIT;
		end else if (CE_I) begin
			if (take) begin
				bus_q <= BUS_DONE;
			end else begin
				bus_q <= BUS_WAIT;
			end
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (hit(sel, REG_CNT_HI) || hit(sel, REG_ALT_HI)) begin
			rd_mux = cnt_q[15:8];
		end else if (hit(sel, REG_CNT_LO) || hit(sel, REG_ALT_LO)) begin
			rd_mux = seq_q ? lo_buf_q : cnt_q[7:0];
		end else if (hit(sel, REG_CAP1_HI)) begin
			rd_mux = cap_q[0][15:8];
		end else if (hit(sel, REG_CAP1_LO)) begin
			rd_mux = cap_q[0][7:0];
		end else if (hit(sel, REG_CAP2_HI)) begin
			rd_mux = cap_q[1][15:8];
		end else if (hit(sel, REG_CAP2_LO)) begin
			rd_mux = cap_q[1][7:0];
		end else if (hit(sel, REG_CTRL1)) begin
			rd_mux = ctrl1_q;
		end else if (hit(sel, REG_CTRL2)) begin
			rd_mux = ctrl2_q;
		end else if (hit(sel, REG_STATUS)) begin
			rd_mux = status;
		end else begin
			rd_mux = 8'h00;
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			rdata_q <= RDATA_RESET;
		end else if (CE_I) begin
			if (rd_take) begin
				rdata_q <= {24'h00_0000, rd_mux};
			end
		end
	end

	// Waitrequest kept in a flop of its own so the pin is a register output
	// High again in the cycle after the acknowledge, matching the bus state
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			waitreq_q <= 1'b1;
		end else if (CE_I) begin
			waitreq_q <= !take;
		end
	end

	assign AVS_READDATA_O    = rdata_q;
	assign AVS_WAITREQUEST_O = waitreq_q;

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctrl1_q <= CTRL_RESET;
			ctrl2_q <= CTRL_RESET;
		end else if (CE_I) begin
			if (wr_take && hit(sel, REG_CTRL1)) begin
				ctrl1_q <= AVS_REQ_I.writedata[7:0];
			end
			if (wr_take && hit(sel, REG_CTRL2)) begin
				ctrl2_q <= AVS_REQ_I.writedata[7:0];
			end
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Absent pins read high
	assign pin_raw = {EXTERNAL_CLOCK_PIN_I, CAP2_I, CAP1_I} | ~PIN_PRESENT;

	// All three pins pass two synchroniser flops, then one edge-detect flop
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			prev_q  <= 3'h7;
		end else if (CE_I) begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// ****************************************
	// Prescaler and counter
	// ****************************************
	assign csel     = {ctrl2_q[CTRL2_CSEL_HI], ctrl2_q[CTRL2_CSEL_LO]};
	assign run      = !HALT_I;
	// Edge spacing of four clocks is the source's duty
	assign ext_edge = ctrl2_q[CTRL2_EXT_EDG] ? (sync2_q[2] && !prev_q[2]) :
	                  (!sync2_q[2] && prev_q[2]);

	always_comb begin
		tick = 1'b0;
		if (csel == CSEL_EXT) begin
			tick = ext_edge;
		end else if (csel == DIV2_CODE) begin
			tick = presc_q[0];
		end else if (csel == DIV4_CODE) begin
			tick = (presc_q[1:0] == 2'h3);
		end else if (csel == DIV8_CODE) begin
			tick = (presc_q == 3'h7);
		end else begin
			tick = 1'b0;
		end
	end

	assign reload     = wr_take && (hit(sel, REG_CNT_LO) || hit(sel, REG_ALT_LO));
	assign ovf_evt    = run && tick && !reload && (cnt_q == CNT_MAX);
	assign cnt_lo_acc = take && hit(sel, REG_CNT_LO);

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			presc_q <= PRESC_RESET;
		end else if (CE_I) begin
			if (reload) begin
				presc_q <= PRESC_RESET;
			end else if (run) begin
				presc_q <= presc_q + 3'h1;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			cnt_q <= CNT_RELOAD;
		end else if (CE_I) begin
			if (reload) begin
				cnt_q <= CNT_RELOAD;
			end else if (run && tick) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	assign COUNT_O = cnt_q;

	// ****************************************
	// Coherent 16-bit read
	// ****************************************
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			seq_q    <= 1'b0;
			lo_buf_q <= 8'h00;
		end else if (CE_I) begin
			if (rd_take && (hit(sel, REG_CNT_HI) || hit(sel, REG_ALT_HI)) && !seq_q) begin
				seq_q    <= 1'b1;
				lo_buf_q <= cnt_q[7:0];
			end else if (rd_take && (hit(sel, REG_CNT_LO) || hit(sel, REG_ALT_LO))) begin
				seq_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Overflow flag
	// ****************************************
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ovf_q     <= 1'b0;
			ovf_arm_q <= 1'b0;
		end else if (CE_I) begin
			if (ovf_evt) begin
				ovf_q <= 1'b1;
			end else if (ovf_arm_q && cnt_lo_acc) begin
				ovf_q <= 1'b0;
			end
			if (rd_take && hit(sel, REG_STATUS) && ovf_q) begin
				ovf_arm_q <= 1'b1;
			end else if (cnt_lo_acc) begin
				ovf_arm_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Capture channels
	// ****************************************
	generate
		for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
			logic       edg_sel;
			logic       rise;
			logic       fall;
			logic       enab;
			logic [3:0] hi_reg;
			logic [3:0] lo_reg;
			logic       lo_acc;

			assign hi_reg  = (i == 0) ? REG_CAP1_HI : REG_CAP2_HI;
			assign lo_reg  = (i == 0) ? REG_CAP1_LO : REG_CAP2_LO;
			assign edg_sel = (i == 0) ? ctrl1_q[CTRL1_CAP1_EDG] :
			                 ctrl2_q[CTRL2_CAP2_EDG];
			assign enab    = (i != 0) ||
			                 !(ctrl2_q[CTRL2_OPM] || ctrl2_q[CTRL2_PWM]);
			assign rise    = sync2_q[i] && !prev_q[i];
			assign fall    = !sync2_q[i] && prev_q[i];
			assign cap_evt[i] = enab && (edg_sel ? rise : fall);
			assign lo_acc  = take && hit(sel, lo_reg);

			always_ff @(posedge CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					cap_q[i] <= CAP_RESET;
				end else if (CE_I) begin
					if (cap_evt[i] && !cap_blk_q[i]) begin
						cap_q[i] <= cnt_q;
					end
				end
			end

			always_ff @(posedge CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					cap_blk_q[i] <= 1'b0;
				end else if (CE_I) begin
					if (rd_take && hit(sel, hi_reg)) begin
						cap_blk_q[i] <= 1'b1;
					end else if (rd_take && hit(sel, lo_reg)) begin
						cap_blk_q[i] <= 1'b0;
					end
				end
			end

			always_ff @(posedge CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					cap_flag_q[i] <= 1'b0;
					cap_arm_q[i]  <= 1'b0;
				end else if (CE_I) begin
					if (cap_evt[i]) begin
						cap_flag_q[i] <= 1'b1;
					end else if (cap_arm_q[i] && lo_acc) begin
						cap_flag_q[i] <= 1'b0;
					end
					if (rd_take && hit(sel, REG_STATUS) && cap_flag_q[i]) begin
						cap_arm_q[i] <= 1'b1;
					end else if (lo_acc) begin
						cap_arm_q[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Status and interrupt
	// ****************************************
	always_comb begin
		status                 = 8'h00;
		status[STAT_CAP1_FLAG] = cap_flag_q[0];
		status[STAT_OVF_FLAG]  = ovf_q;
		status[STAT_CAP2_FLAG] = cap_flag_q[1];
	end

	// Requests stay pending in the flags while masked
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			irq_q <= 1'b0;
		end else if (CE_I) begin
			irq_q <= !IMASK_I && ((ovf_q && ctrl1_q[CTRL1_OVF_IE]) ||
			         ((cap_flag_q[0] || cap_flag_q[1]) && ctrl1_q[CTRL1_CAP_IE]));
		end
	end

	assign IRQ_O = irq_q;

endmodule
